// [src/ubs_defines.vh]
// Constants for the baud-sampling serial port: byte addresses, control fields, resets
`ifndef UBS_DEFINES_VH
`define UBS_DEFINES_VH

// Byte register addresses
`define UBS_ADDR_CTL      3'h0
`define UBS_ADDR_DIV_HI   3'h1
`define UBS_ADDR_DIV_LO   3'h2
`define UBS_ADDR_MOD      3'h3
`define UBS_ADDR_TX_BUF   3'h4
`define UBS_ADDR_RX_BUF   3'h5
`define UBS_ADDR_STATUS   3'h6

// Control byte fields
`define UBS_CTL_SYNC      0
`define UBS_CTL_MASTER    1
`define UBS_CTL_CHAR7     2
`define UBS_CTL_FOUR_WIRE 3
`define UBS_CTL_POL       4
`define UBS_CTL_PHASE     5
`define UBS_CTL_SRC_LO    6
`define UBS_CTL_SRC_HI    7

// Baud source clock choices
`define UBS_SRC_AUX       2'h0
`define UBS_SRC_MAIN      2'h1
`define UBS_SRC_EXT       2'h2

// Status byte fields
`define UBS_ST_RX_FULL    0
`define UBS_ST_OVERRUN    1
`define UBS_ST_FRAME_ERR  2
`define UBS_ST_CONFLICT   3
`define UBS_ST_BUSY       4

// Reset values
`define UBS_RST_CTL       8'h00
`define UBS_RST_DIV_HI    8'h00
`define UBS_RST_DIV_LO    8'h0d
`define UBS_RST_MOD       8'h6b

// UART frame: start, eight data, stop
`define UBS_UART_LAST_BIT 4'h9
`endif

// [src/ubs_fifo.v]
// Transmit holding FIFO with registered full and empty flags
`timescale 1ns/10ps
module ubs_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             rst_n,
  // Filling side
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Draining side
  output reg              out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr;
  reg  [AW-1:0]    rd_ptr;
  reg  [AW:0]      count;
  wire             push = in_valid & in_ready;
  wire             pop  = out_valid & out_ready;
  reg  [AW:0]      next_count;

  assign out_data = mem[rd_ptr];

  // Occupancy after this cycle
  always @* begin
    next_count = count;
    if (push & ~pop)
      next_count = count + 1'b1;
    else if (pop & ~push)
      next_count = count - 1'b1;
  end

  // Pointers, storage and flags
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= (wr_ptr == DEPTH-1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH-1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      count     <= next_count;
      in_ready  <= (next_count != DEPTH);
      out_valid <= (next_count != 0);
    end
  end
endmodule

// [src/ubs_port.v]
// Serial port: baud divider with modulation, receive sampling, UART and SPI engines
`timescale 1ns/10ps
`include "ubs_defines.vh"

// Functional notes
// - Sample clock divides source by divider range
// - Receive line synchronised on sample clock
// - Start tested half bit, then full bits
// - Modulation bit per frame bit, LSB first
// - Divider is high byte then low byte
// - Divider integer, modulation supplies fraction
// - One control bit selects UART or SPI
// - Internal rate or external serial clock
// - SPI character length seven or eight
// - Three-wire and four-wire SPI operation
// - Separate shift registers; receive double buffered, transmit behind FIFO
// - Clock polarity, phase; master sets frequency
// - All registers accessed as bytes
module ubs_port #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // Byte register port
  input  wire       wr_en,
  input  wire [2:0] wr_addr,
  input  wire [7:0] wr_data,
  input  wire       rd_en,
  input  wire [2:0] rd_addr,
  output reg  [7:0] rd_data,
  output wire       tx_buffer_ready,
  // Baud source inputs
  input  wire       aux_clock_tick,
  // Asynchronous lines
  input  wire       async_receive_line,
  output reg        async_transmit_line,
  // SPI pins
  input  wire       serial_clock_pin_in,
  output reg        serial_clock_pin_out,
  output reg        serial_clock_pin_oe_n,
  input  wire       host_out_peer_in_in,
  output reg        host_out_peer_in_out,
  output reg        host_out_peer_in_oe_n,
  input  wire       peer_out_host_in_in,
  output reg        peer_out_host_in_out,
  output reg        peer_out_host_in_oe_n,
  input  wire       peer_select_line,
  // Status
  output reg        rx_ready,
  output reg        rx_error
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_DATA  = 2'h2;

  // Sample-clock mask: divide by one up to 0x1f, doubling per range
  function [10:0] sample_mask;
    input [15:0] div;
    integer j;
    begin
      sample_mask = 11'h000;
      for (j = 5; j < 16; j = j + 1)
        if (div[j])
          sample_mask = (11'h7ff >> (15 - j));
    end
  endfunction

  // Bit length in source ticks: divider plus modulation bit of this frame bit
  function [16:0] bit_len;
    input [15:0] div;
    input [7:0]  mod;
    input [2:0]  idx;
    begin
      bit_len = {1'b0, div} + {16'h0000, mod[idx]};
    end
  endfunction

  // Reset release through two flops
  reg rst_a;
  reg rst_s;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_a <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_s <= rst_a;
    end
  end

  // Byte registers
  reg  [7:0]  ctl;
  reg  [7:0]  div_hi;
  reg  [7:0]  div_lo;
  reg  [7:0]  mod;
  wire [15:0] div       = {div_hi, div_lo};
  wire        sync_mode = ctl[`UBS_CTL_SYNC];
  wire        master    = ctl[`UBS_CTL_MASTER];
  wire        char7     = ctl[`UBS_CTL_CHAR7];
  wire        four_wire = ctl[`UBS_CTL_FOUR_WIRE];
  wire        pol       = ctl[`UBS_CTL_POL];
  wire        phase     = ctl[`UBS_CTL_PHASE];
  wire [1:0]  src_sel   = ctl[`UBS_CTL_SRC_HI:`UBS_CTL_SRC_LO];

  // Transmit holding FIFO
  wire       fifo_valid;
  wire [7:0] fifo_data;
  reg        fifo_pop;
  ubs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_tx_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_s),
    .in_valid  (wr_en && wr_addr == `UBS_ADDR_TX_BUF),
    .in_ready  (tx_buffer_ready),
    .in_data   (wr_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // Baud source selection, external clock by rising edge
  reg  sclk_prev;
  wire src_tick = (src_sel == `UBS_SRC_AUX)  ? aux_clock_tick :
                  (src_sel == `UBS_SRC_EXT)  ? (serial_clock_pin_in & ~sclk_prev) :
                  1'b1;

  // Receive sample clock and line synchroniser
  reg  [10:0] smp_cnt;
  reg         rx_s1;
  reg         rx_s2;
  reg         rx_last;
  wire        smp_tick = src_tick && ((smp_cnt | ~sample_mask(div)) == 11'h7ff);
  always @(posedge clk_sys or negedge rst_s) begin
    if (!rst_s) begin
      smp_cnt <= 11'h000;
      rx_s1   <= 1'b1;
      rx_s2   <= 1'b1;
      rx_last <= 1'b1;
    end else begin
      if (src_tick)
        smp_cnt <= smp_cnt + 1'b1;
      if (smp_tick) begin
        rx_s1   <= async_receive_line;
        rx_s2   <= rx_s1;
        rx_last <= rx_s2;
      end
    end
  end

  // UART receiver: half bit to start test, then full modulated bits
  reg  [1:0]  rx_state;
  reg  [16:0] rx_cnt;
  reg  [3:0]  rx_idx;
  reg  [7:0]  rx_sh;
  reg  [16:0] rx_target;
  reg         uart_rx_done;
  reg         uart_frame_err;
  reg  [7:0]  uart_rx_byte;
  wire        rx_event = src_tick && (rx_cnt + 17'h00001 >= rx_target);
  always @* begin
    if (rx_state == ST_START)
      rx_target = {2'b00, div[15:1]} + {16'h0000, mod[0]};
    else
      rx_target = bit_len(div, mod, rx_idx[2:0]);
  end
  always @(posedge clk_sys or negedge rst_s) begin
    if (!rst_s) begin
      rx_state       <= ST_IDLE;
      rx_cnt         <= 17'h00000;
      rx_idx         <= 4'h0;
      rx_sh          <= 8'h00;
      uart_rx_done   <= 1'b0;
      uart_frame_err <= 1'b0;
      uart_rx_byte   <= 8'h00;
    end else begin
      uart_rx_done   <= 1'b0;
      uart_frame_err <= 1'b0;
      case (rx_state)
        ST_IDLE: begin
          rx_cnt <= 17'h00000;
          if (!sync_mode && smp_tick && rx_last && !rx_s2) begin
            rx_state <= ST_START;
            rx_idx   <= 4'h0;
          end
        end
        ST_START: begin
          rx_cnt <= src_tick ? rx_cnt + 1'b1 : rx_cnt;
          if (rx_event) begin
            rx_cnt   <= 17'h00000;
            rx_idx   <= 4'h1;
            rx_state <= rx_s2 ? ST_IDLE : ST_DATA;          // Glitch rejected
          end
        end
        ST_DATA: begin
          rx_cnt <= src_tick ? rx_cnt + 1'b1 : rx_cnt;
          if (rx_event) begin
            rx_cnt <= 17'h00000;
            rx_idx <= rx_idx + 1'b1;
            if (rx_idx == `UBS_UART_LAST_BIT) begin
              rx_state       <= ST_IDLE;
              uart_rx_done   <= 1'b1;
              uart_rx_byte   <= rx_sh;
              uart_frame_err <= ~rx_s2;
            end else
              rx_sh <= {rx_s2, rx_sh[7:1]};
          end
        end
        default: rx_state <= ST_IDLE;
      endcase
    end
  end

  // UART transmitter and SPI shift engine share the transmit shift register
  reg  [9:0]  tx_sh;
  reg         tx_busy;
  reg  [16:0] tx_cnt;
  reg  [3:0]  tx_idx;
  reg  [7:0]  spi_rx_sh;
  reg  [3:0]  spi_bits;
  reg  [4:0]  spi_edges;
  reg         spi_first;
  reg         sclk_lvl;
  reg  [15:0] half_cnt;
  reg         spi_rx_done;
  wire [3:0]  char_len  = char7 ? 4'h7 : 4'h8;
  wire        conflict  = sync_mode && master && four_wire && !peer_select_line;
  wire        slave_en  = !four_wire || !peer_select_line;
  wire        m_toggle  = sync_mode && master && tx_busy && !conflict && src_tick &&
                          (half_cnt + 16'h0001 >= div);
  wire        s_change  = sync_mode && !master && slave_en && (serial_clock_pin_in != sclk_prev);
  wire        clk_now   = master ? sclk_lvl : sclk_prev;
  wire        edge_evt  = m_toggle || (s_change && tx_busy);
  wire        lead      = edge_evt && (clk_now == pol);
  wire        trail     = edge_evt && (clk_now != pol);
  wire        capture   = phase ? trail : lead;
  wire        shift_out = phase ? lead : trail;
  wire        rx_pin    = master ? peer_out_host_in_in : host_out_peer_in_in;
  wire        can_load  = !tx_busy && fifo_valid && (sync_mode ? !conflict : 1'b1);
  always @* begin
    fifo_pop = can_load;
  end
  always @(posedge clk_sys or negedge rst_s) begin
    if (!rst_s) begin
      tx_sh       <= 10'h3ff;
      tx_busy     <= 1'b0;
      tx_cnt      <= 17'h00000;
      tx_idx      <= 4'h0;
      spi_rx_sh   <= 8'h00;
      spi_bits    <= 4'h0;
      spi_edges   <= 5'h00;
      spi_first   <= 1'b1;
      sclk_lvl    <= 1'b0;
      sclk_prev   <= 1'b0;
      half_cnt    <= 16'h0000;
      spi_rx_done <= 1'b0;
    end else begin
      sclk_prev   <= serial_clock_pin_in;
      spi_rx_done <= 1'b0;
      if (!tx_busy)
        sclk_lvl <= pol;                                    // Idle level follows polarity
      if (can_load) begin
        tx_busy   <= 1'b1;
        tx_cnt    <= 17'h00000;
        tx_idx    <= 4'h0;
        spi_bits  <= 4'h0;
        spi_edges <= 5'h00;
        spi_first <= 1'b1;
        half_cnt  <= 16'h0000;
        if (sync_mode)
          tx_sh <= {2'b11, fifo_data};                      // Seven-bit sends upper bits
        else
          tx_sh <= {1'b1, fifo_data, 1'b0};
      end else if (tx_busy && !sync_mode) begin
        tx_cnt <= src_tick ? tx_cnt + 1'b1 : tx_cnt;
        if (src_tick && (tx_cnt + 17'h00001 >= bit_len(div, mod, tx_idx[2:0]))) begin
          tx_cnt <= 17'h00000;
          tx_sh  <= {1'b1, tx_sh[9:1]};
          tx_idx <= tx_idx + 1'b1;
          if (tx_idx == `UBS_UART_LAST_BIT)
            tx_busy <= 1'b0;
        end
      end else if (tx_busy) begin
        if (master && !conflict && src_tick)
          half_cnt <= m_toggle ? 16'h0000 : half_cnt + 1'b1;
        if (m_toggle) begin
          sclk_lvl  <= ~sclk_lvl;
          spi_edges <= spi_edges + 1'b1;
        end
        if (shift_out) begin
          spi_first <= 1'b0;
          if (!(phase && spi_first))
            tx_sh <= {tx_sh[8:0], 1'b0};                    // MSB first
        end
        if (capture) begin
          spi_rx_sh <= char7 ? {1'b0, spi_rx_sh[5:0], rx_pin} : {spi_rx_sh[6:0], rx_pin};
          spi_bits  <= spi_bits + 1'b1;
          if (spi_bits + 4'h1 == char_len) begin
            spi_rx_done <= 1'b1;
            if (!master)
              tx_busy <= 1'b0;
          end
        end
        if (m_toggle && (spi_edges + 5'h01 == {char_len, 1'b0}))
          tx_busy <= 1'b0;
      end
    end
  end

  // Receive holding buffer, status flags and register file
  reg [7:0] rx_buf;
  reg       rx_full;
  reg       overrun;
  reg       frame_err;
  reg       conflict_seen;
  wire      rx_load  = uart_rx_done || spi_rx_done;
  wire [7:0] rx_word = sync_mode ? (char7 ? {1'b0, spi_rx_sh[6:0]} : spi_rx_sh) : uart_rx_byte;
  wire      rd_rxbuf = rd_en && rd_addr == `UBS_ADDR_RX_BUF;
  wire      rd_stat  = rd_en && rd_addr == `UBS_ADDR_STATUS;
  wire [7:0] status  = {3'b000, tx_busy, conflict_seen, frame_err, overrun, rx_full};
  always @(posedge clk_sys or negedge rst_s) begin
    if (!rst_s) begin
      ctl           <= `UBS_RST_CTL;
      div_hi        <= `UBS_RST_DIV_HI;
      div_lo        <= `UBS_RST_DIV_LO;
      mod           <= `UBS_RST_MOD;
      rx_buf        <= 8'h00;
      rx_full       <= 1'b0;
      overrun       <= 1'b0;
      frame_err     <= 1'b0;
      conflict_seen <= 1'b0;
      rd_data       <= 8'h00;
    end else begin
      // Byte writes
      if (wr_en) begin
        case (wr_addr)
          `UBS_ADDR_CTL:    ctl    <= wr_data;
          `UBS_ADDR_DIV_HI: div_hi <= wr_data;
          `UBS_ADDR_DIV_LO: div_lo <= wr_data;
          `UBS_ADDR_MOD:    mod    <= wr_data;
          default: ;
        endcase
      end
      // Byte reads, receive buffer read empties it; a new load wins
      case (rd_addr)
        `UBS_ADDR_CTL:    rd_data <= rd_en ? ctl : rd_data;
        `UBS_ADDR_DIV_HI: rd_data <= rd_en ? div_hi : rd_data;
        `UBS_ADDR_DIV_LO: rd_data <= rd_en ? div_lo : rd_data;
        `UBS_ADDR_MOD:    rd_data <= rd_en ? mod : rd_data;
        `UBS_ADDR_RX_BUF: rd_data <= rd_en ? rx_buf : rd_data;
        `UBS_ADDR_STATUS: rd_data <= rd_en ? status : rd_data;
        default:          rd_data <= rd_en ? 8'h00 : rd_data;
      endcase
      if (rx_load) begin
        rx_buf  <= rx_word;
        rx_full <= 1'b1;
        if (rx_full && !rd_rxbuf)
          overrun <= 1'b1;
      end else if (rd_rxbuf)
        rx_full <= 1'b0;
      if (uart_frame_err)
        frame_err <= 1'b1;
      else if (rd_stat)
        frame_err <= 1'b0;
      if (conflict)
        conflict_seen <= 1'b1;
      else if (rd_stat)
        conflict_seen <= 1'b0;
      if (rd_stat && !(rx_load && rx_full && !rd_rxbuf))
        overrun <= 1'b0;
    end
  end

  // Registered pin drivers and status outputs
  always @(posedge clk_sys or negedge rst_s) begin
    if (!rst_s) begin
      async_transmit_line   <= 1'b1;
      serial_clock_pin_out  <= 1'b0;
      serial_clock_pin_oe_n <= 1'b1;
      host_out_peer_in_out  <= 1'b0;
      host_out_peer_in_oe_n <= 1'b1;
      peer_out_host_in_out  <= 1'b0;
      peer_out_host_in_oe_n <= 1'b1;
      rx_ready              <= 1'b0;
      rx_error              <= 1'b0;
    end else begin
      async_transmit_line   <= (sync_mode || !tx_busy) ? 1'b1 : tx_sh[0];
      serial_clock_pin_out  <= sclk_lvl;
      serial_clock_pin_oe_n <= !(sync_mode && master && !conflict);
      host_out_peer_in_out  <= tx_sh[7];
      host_out_peer_in_oe_n <= !(sync_mode && master && !conflict);
      peer_out_host_in_out  <= tx_sh[7];
      peer_out_host_in_oe_n <= !(sync_mode && !master && slave_en);
      rx_ready              <= rx_full;
      rx_error              <= overrun | frame_err | conflict_seen;
    end
  end
endmodule

// [tb/ubs_port_chk.sv]
// Checker for register reads, line idle levels, pin release and buffer flags
`timescale 1ns/10ps
`include "ubs_defines.vh"
module ubs_port_chk (
  // Clock and reset
  input wire       clk_sys,
  input wire       rst_n,
  // Register port
  input wire       wr_en,
  input wire [2:0] wr_addr,
  input wire [7:0] wr_data,
  input wire       rd_en,
  input wire [2:0] rd_addr,
  input wire [7:0] rd_data,
  input wire       tx_buffer_ready,
  // Lines and pins
  input wire       async_transmit_line,
  input wire       serial_clock_pin_oe_n,
  input wire       host_out_peer_in_oe_n,
  input wire       peer_out_host_in_oe_n,
  input wire       peer_select_line,
  // Status
  input wire       rx_ready,
  input wire       rx_error
);
  reg  [7:0]  sh [0:3];
  reg  [15:0] low_run;
  wire [7:0]  sh_sel  = sh[rd_addr[1:0]];
  wire        master4 = sh[0][0] & sh[0][1] & sh[0][3];
  wire [16:0] start_len = {1'b0, sh[1], sh[2]} + {16'h0000, sh[3][0]};
  // Shadow of the writable bytes and length of the current low run
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sh[0] <= `UBS_RST_CTL;
      sh[1] <= `UBS_RST_DIV_HI;
      sh[2] <= `UBS_RST_DIV_LO;
      sh[3] <= `UBS_RST_MOD;
      low_run <= 16'h0000;
    end else begin
      if (wr_en && !wr_addr[2])
        sh[wr_addr[1:0]] <= wr_data;
      low_run <= async_transmit_line ? 16'h0000 : low_run + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_rd_hold: assert property (!$past(rd_en) |-> $stable(rd_data))
    else $error("read data moved without a read");
  chk_rd_map: assert property (rd_en && !rd_addr[2] |=> rd_data == $past(sh_sel))
    else $error("byte read back differs from byte written");
  chk_rd_unmapped: assert property (rd_en && rd_addr == 3'h7 |=> rd_data == 8'h00)
    else $error("unmapped byte not zero");
  chk_spi_tx_idle: assert property (sh[0][0] [*3] |-> async_transmit_line)
    else $error("async line not idle in synchronous mode");
  chk_uart_pins_off: assert property ((!sh[0][0]) [*3] |->
    serial_clock_pin_oe_n && host_out_peer_in_oe_n && peer_out_host_in_oe_n)
    else $error("spi pin driven in async mode");
  chk_conflict_off: assert property ((master4 && !peer_select_line) [*4] |->
    serial_clock_pin_oe_n && host_out_peer_in_oe_n)
    else $error("master drives bus while select low");
  chk_conflict_err: assert property (master4 && $fell(peer_select_line) |-> ##[1:6] rx_error)
    else $error("conflict not flagged");
  chk_start_len: assert property ($rose(async_transmit_line) && !sh[0][0] && sh[0][6] |->
    {1'b0, low_run} >= start_len)
    else $error("low run shorter than start bit");
  chk_rx_clear: assert property (rx_ready && rd_en && rd_addr == 3'h5 |-> ##2 !rx_ready)
    else $error("receive ready kept after buffer read");
  chk_fifo_fill: assert property ($fell(tx_buffer_ready) |-> $past(wr_en && wr_addr == 3'h4))
    else $error("buffer ready fell without a write");
  cover property ($rose(rx_ready));
  cover property ($fell(tx_buffer_ready));
  cover property (master4 && !peer_select_line);
  cover property (!serial_clock_pin_oe_n);
endmodule

// [tb/ubs_peer.sv]
// Remote serial device: async frame sender and receiver, SPI slave
`timescale 1ns/10ps
module ubs_peer (
  // Clock
  input  wire       clk_sys,
  // Async lines
  output reg        rx_line,
  input  wire       tx_line,
  // SPI settings and pins
  input  wire       pol,
  input  wire       phase,
  input  wire       sclk,
  input  wire       mosi,
  output reg        miso,
  input  wire [7:0] spi_tx,
  input  wire       spi_load,
  output reg  [7:0] spi_rx
);
  reg       sclk_q = 1'b0;
  reg [7:0] shift = 8'h00;
  wire      lead  = (sclk != sclk_q) && (sclk != pol);
  wire      trail = (sclk != sclk_q) && (sclk == pol);
  initial rx_line = 1'b1;
  initial miso = 1'b0;
  // Slave: MSB first, capture and shift on opposite edges
  always @(posedge clk_sys) begin
    sclk_q <= sclk;
    if (spi_load) begin
      shift <= spi_tx;
      spi_rx <= 8'h00;
      miso <= phase ? ~spi_tx[7] : spi_tx[7];
    end else if (phase ? trail : lead) begin
      spi_rx <= {spi_rx[6:0], mosi};
    end else if (phase ? lead : trail) begin
      shift <= shift << 1;
      miso <= phase ? shift[7] : shift[6];
    end
  end
  // Send a frame; each bit lasts divider plus its modulation bit
  task automatic send_byte(input [15:0] dv, input [7:0] md, input [7:0] b, input stp);
    integer   i;
    reg [9:0] fr;
    begin
      fr = {stp, b, 1'b0};
      for (i = 0; i < 10; i = i + 1) begin
        rx_line <= fr[i];
        repeat (dv + md[i % 8]) @(negedge clk_sys);
      end
      rx_line <= 1'b1;
    end
  endtask
  // Catch a frame, sampling each bit in its middle
  task automatic get_byte(input [15:0] dv, input [7:0] md, input integer sc, output [9:0] fr);
    integer i;
    integer n;
    integer len;
    begin
      fr = 10'h000;
      n = 0;
      while (tx_line && n < 2000) begin
        @(negedge clk_sys);
        n = n + 1;
      end
      for (i = 0; i < 10; i = i + 1) begin
        len = sc * (dv + md[i % 8]);
        repeat (len / 2) @(negedge clk_sys);
        fr[i] = tx_line;
        repeat (len - len / 2) @(negedge clk_sys);
      end
    end
  endtask
endmodule

// [tb/tb_top.sv]
// Bench for the serial port: registers, async frames, buffer and SPI
`timescale 1ns/10ps
`include "ubs_defines.vh"
`define UBS_CMP(what, exp, got) begin checks = checks + 1; if ((got) !== (exp)) begin \
  mismatches = mismatches + 1; $display("Error %s expected %h seen %h", what, exp, got); end end
module tb_top;
  reg  clk_sys = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, aux_tick = 1'b0;
  reg  ext_clk = 1'b0, ext_run = 1'b0, ec = 1'b0, sel = 1'b1, pol = 1'b0, phase = 1'b0;
  reg  spi_load = 1'b0;
  reg  [1:0] ac = 2'h0;
  reg  [2:0] wr_addr = 3'h0, rd_addr = 3'h0;
  reg  [7:0] wr_data = 8'h00, spi_tx = 8'h00, r;
  reg  [9:0] f;
  wire [7:0] rd_data, spi_rx;
  wire txr, rxl, txl, sck_o, sck_oe, mo_o, mo_oe, mi_o, mi_oe, mi_i, rx_ready, rx_error;
  wire sck  = sck_oe ? ext_clk : sck_o;
  wire mosi = mo_oe ? 1'b1 : mo_o;
  integer mismatches = 0, checks = 0, i, n, k;
  logic [7:0]  rst_vals [4] = '{8'h00, 8'h00, 8'h0d, 8'h6b};
  logic [18:0] reg_rows [5] = '{{3'h1, 8'ha5, 8'ha5}, {3'h2, 8'h3c, 8'h3c},
    {3'h3, 8'hf0, 8'hf0}, {3'h6, 8'hff, 8'h00}, {3'h7, 8'hff, 8'h00}};
  logic [19:0] tx_rows [3] = '{{8'h40, 4'h1, 8'h96}, {8'h00, 4'h3, 8'h5a}, {8'h80, 4'h4, 8'hc1}};
  logic [32:0] rx_rows [4] = '{{24'h000d6b, 8'ha5, 1'b1}, {24'h000908, 8'h3c, 1'b1},
    {24'h004000, 8'hc3, 1'b1}, {24'h000908, 8'h5a, 1'b0}};
  logic [39:0] spi_rows [5] = '{{32'h43a53c3c, 8'ha5}, {32'h53966969, 8'h96},
    {32'h630ff0f0, 8'h0f}, {32'h73c38181, 8'hc3}, {32'h47b0984c, 8'h58}};
  ubs_port u_ubs_port (.clk_sys, .rst_n, .wr_en, .wr_addr, .wr_data, .rd_en, .rd_addr,
    .rd_data, .tx_buffer_ready(txr), .aux_clock_tick(aux_tick), .async_receive_line(rxl),
    .async_transmit_line(txl), .serial_clock_pin_in(sck), .serial_clock_pin_out(sck_o),
    .serial_clock_pin_oe_n(sck_oe), .host_out_peer_in_in(mosi), .host_out_peer_in_out(mo_o),
    .host_out_peer_in_oe_n(mo_oe), .peer_out_host_in_in(mi_i), .peer_out_host_in_out(mi_o),
    .peer_out_host_in_oe_n(mi_oe), .peer_select_line(sel), .rx_ready, .rx_error);
  ubs_peer u_ubs_peer (.clk_sys, .rx_line(rxl), .tx_line(txl), .pol, .phase, .sclk(sck),
    .mosi, .miso(mi_i), .spi_tx, .spi_load, .spi_rx);
  initial forever #12.5 clk_sys = ~clk_sys;
  // Aux tick every third cycle; external clock rises every fourth while running
  always @(negedge clk_sys) begin
    ac <= (ac == 2'h2) ? 2'h0 : ac + 2'h1;
    aux_tick <= (ac == 2'h2);
    ec <= ~ec;
    ext_clk <= ext_run ? ext_clk ^ ec : 1'b0;
  end
  task acc(input w, input [2:0] a, input [7:0] d, output [7:0] q);
    begin
      wr_en <= w;
      rd_en <= !w;
      wr_addr <= a;
      rd_addr <= a;
      wr_data <= d;
      @(negedge clk_sys);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      @(negedge clk_sys);
      q = rd_data;
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task wait_rx;
    begin
      k = 0;
      while (rx_ready !== 1'b1 && k < 4000) begin
        @(negedge clk_sys);
        k = k + 1;
      end
      if (k == 4000) begin
        mismatches = mismatches + 1;
        end_of_test;
      end
    end
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk_sys);
    for (i = 0; i < 4; i = i + 1) begin
      acc(0, i[2:0], 8'h00, r);
      `UBS_CMP("reset byte", rst_vals[i], r)
    end
    for (i = 0; i < 5; i = i + 1) begin
      acc(1, reg_rows[i][18:16], reg_rows[i][15:8], r);
      acc(0, reg_rows[i][18:16], 8'h00, r);
      `UBS_CMP("byte readback", reg_rows[i][7:0], r)
    end
    $display("test registers done");
    acc(1, `UBS_ADDR_DIV_HI, 8'h00, r);
    acc(1, `UBS_ADDR_DIV_LO, 8'h05, r);
    acc(1, `UBS_ADDR_MOD, 8'h0a, r);
    for (i = 0; i < 3; i = i + 1) begin
      acc(1, `UBS_ADDR_CTL, tx_rows[i][19:12], r);
      ext_run <= (i == 2);
      acc(1, `UBS_ADDR_TX_BUF, tx_rows[i][7:0], r);
      u_ubs_peer.get_byte(16'h0005, 8'h0a, tx_rows[i][11:8], f);
      `UBS_CMP("sent frame", {1'b1, tx_rows[i][7:0], 1'b0}, f)
    end
    ext_run <= 1'b0;
    $display("test transmit sources done");
    acc(1, `UBS_ADDR_CTL, 8'h80, r);
    n = 0;
    while (txr === 1'b1 && n < 12) begin
      acc(1, `UBS_ADDR_TX_BUF, 8'h10 + n[7:0], r);
      n = n + 1;
    end
    `UBS_CMP("bytes taken", 9, n)
    acc(1, `UBS_ADDR_TX_BUF, 8'hee, r);
    ext_run <= 1'b1;
    for (i = 0; i < n; i = i + 1) begin
      u_ubs_peer.get_byte(16'h0005, 8'h0a, 4, f);
      `UBS_CMP("queued frame", {1'b1, 8'h10 + i[7:0], 1'b0}, f)
    end
    k = 0;
    while (txl === 1'b1 && k < 200) begin
      @(negedge clk_sys);
      k = k + 1;
    end
    `UBS_CMP("line idle", 1'b1, txl)
    $display("test buffer done");
    ext_run <= 1'b0;
    acc(1, `UBS_ADDR_CTL, 8'h40, r);
    for (i = 0; i < 4; i = i + 1) begin
      acc(1, `UBS_ADDR_DIV_LO, rx_rows[i][24:17], r);
      acc(1, `UBS_ADDR_MOD, rx_rows[i][16:9], r);
      u_ubs_peer.send_byte(rx_rows[i][32:17], rx_rows[i][16:9], rx_rows[i][8:1], rx_rows[i][0]);
      wait_rx;
      acc(0, `UBS_ADDR_RX_BUF, 8'h00, r);
      `UBS_CMP("received byte", rx_rows[i][8:1], r)
      acc(0, `UBS_ADDR_STATUS, 8'h00, r);
      `UBS_CMP("frame error", ~rx_rows[i][0], r[`UBS_ST_FRAME_ERR])
    end
    $display("test receive done");
    acc(1, `UBS_ADDR_DIV_LO, 8'h04, r);
    acc(1, `UBS_ADDR_MOD, 8'h00, r);
    sel <= 1'b0;
    for (i = 0; i < 5; i = i + 1) begin
      acc(1, `UBS_ADDR_CTL, spi_rows[i][39:32], r);
      pol <= spi_rows[i][36];
      phase <= spi_rows[i][37];
      spi_tx <= spi_rows[i][23:16];
      spi_load <= 1'b1;
      repeat (2) @(negedge clk_sys);
      spi_load <= 1'b0;
      acc(1, `UBS_ADDR_TX_BUF, spi_rows[i][31:24], r);
      wait_rx;
      acc(0, `UBS_ADDR_RX_BUF, 8'h00, r);
      `UBS_CMP("master got", spi_rows[i][15:8], r)
      `UBS_CMP("slave got", spi_rows[i][7:0], spi_rx)
    end
    acc(1, `UBS_ADDR_CTL, 8'h41, r);
    acc(1, `UBS_ADDR_TX_BUF, 8'h3c, r);
    ext_run <= 1'b1;
    wait_rx;
    ext_run <= 1'b0;
    acc(0, `UBS_ADDR_RX_BUF, 8'h00, r);
    `UBS_CMP("slave byte", 8'hff, r)
    $display("test spi modes done");
    sel <= 1'b1;
    pol <= 1'b0;
    phase <= 1'b0;
    acc(1, `UBS_ADDR_CTL, 8'h4b, r);
    acc(1, `UBS_ADDR_TX_BUF, 8'h55, r);
    repeat (10) @(negedge clk_sys);
    sel <= 1'b0;
    repeat (8) @(negedge clk_sys);
    `UBS_CMP("clock released", 1'b1, sck_oe)
    acc(0, `UBS_ADDR_STATUS, 8'h00, r);
    `UBS_CMP("conflict flag", 1'b1, r[`UBS_ST_CONFLICT])
    sel <= 1'b1;
    wait_rx;
    `UBS_CMP("transfer resumed", 1'b1, rx_ready)
    $display("test conflict done");
    end_of_test;
  end
endmodule
bind ubs_port ubs_port_chk u_ubs_port_chk (.clk_sys, .rst_n, .wr_en, .wr_addr, .wr_data,
  .rd_en, .rd_addr, .rd_data, .tx_buffer_ready, .async_transmit_line, .serial_clock_pin_oe_n,
  .host_out_peer_in_oe_n, .peer_out_host_in_oe_n, .peer_select_line, .rx_ready, .rx_error);
